// >>> uvm_consts.vh
// constants and rule overview for the undervoltage monitor logic
// Overview of operation
// R1: route one of four monitored sources to the comparator by a 2-bit select.
// R2: select 00 analog supply, 01 first pin, 10 second pin, 11 third pin.
// R3: drive 4-bit threshold code, 0000..1111 meaning 1.8 V to 3.3 V.
// R4: filter enable bit one puts the digital filter before trigger logic.
// R5: filter clock select one uses fast oscillator, zero the 150 kHz RC clock.
// R6: filter width select gives 1,3,7,15,63,255,1023,4095 filter clocks.
// R7: with filter on, pulses shorter than the width cause nothing.
// R8: filter output changes only after input stable for the width; else passes.
// R9: expose filtered level as status and on an observation output pin.
// R10: detector output high while voltage below threshold; falling voltage is rising edge.
// R11: voltage recovering above threshold is a falling edge, caught by rising trigger.
// R12: level trigger fires whenever monitored voltage is below threshold.
// R13: falling trigger fires when voltage crosses from above to below threshold.
// R14: rising trigger fires when voltage crosses from below back above threshold.
// R15: trigger enables independent; any enabled condition met causes a trigger.
// R16: action bit one sends triggers to reset request, zero to interrupt.
// R17: never both interrupt and reset from one detection.
// R18: trigger sets interrupt flag; interrupt line only when enable bit is one.
// R19: software clears the interrupt flag by writing zero; device never clears it.
// R20: flags clear only by software; new event needs clear then new trigger.
// R21: detector and interrupt keep working in low-power modes and can wake.
// R22: software programs all settings first and sets detector enable last.
// R23: software clears the flag at init and in the interrupt handler.
`ifndef UVM_CONSTS_VH
`define UVM_CONSTS_VH

`define UVM_SRC_SUPPLY   2'h0
`define UVM_SRC_PIN_A    2'h1
`define UVM_SRC_PIN_B    2'h2
`define UVM_SRC_PIN_C    2'h3

`define UVM_FW_1         3'h0
`define UVM_FW_3         3'h1
`define UVM_FW_7         3'h2
`define UVM_FW_15        3'h3
`define UVM_FW_63        3'h4
`define UVM_FW_255       3'h5
`define UVM_FW_1023      3'h6
`define UVM_FW_4095      3'h7

`define UVM_CNT_W        12
`define UVM_CNT_ZERO     12'h000
`define UVM_CNT_ONE      12'h001
`define UVM_LIM_1        12'h001
`define UVM_LIM_3        12'h003
`define UVM_LIM_7        12'h007
`define UVM_LIM_15       12'h00f
`define UVM_LIM_63       12'h03f
`define UVM_LIM_255      12'h0ff
`define UVM_LIM_1023     12'h3ff
`define UVM_LIM_4095     12'hfff

`define UVM_SRC_RST      2'h0
`define UVM_TH_RST       4'h0

`endif

// >>> uvm_filter.v
// digital glitch filter running in the main clock with a filter clock tick
`timescale 1ns/1ps
`include "uvm_consts.vh"

module uvm_filter
(
	input  wire       clk,
	input  wire       rst_b,
	input  wire       tick,
	input  wire       filt_on,
	input  wire [2:0] width_sel,
	input  wire       din,
	output reg        dout
);

	reg  [`UVM_CNT_W-1:0] cnt_r;
	reg  [`UVM_CNT_W-1:0] lim;

	// width code to required count of stable filter clocks
	always @*
	begin
		case (width_sel) // R6
			`UVM_FW_1:    lim = `UVM_LIM_1;
			`UVM_FW_3:    lim = `UVM_LIM_3;
			`UVM_FW_7:    lim = `UVM_LIM_7;
			`UVM_FW_15:   lim = `UVM_LIM_15;
			`UVM_FW_63:   lim = `UVM_LIM_63;
			`UVM_FW_255:  lim = `UVM_LIM_255;
			`UVM_FW_1023: lim = `UVM_LIM_1023;
			default:      lim = `UVM_LIM_4095;
		endcase
	end

	// a differing input must persist lim ticks; any return restarts the count
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= `UVM_CNT_ZERO;
			dout  <= 1'b0;
		end
		else if (!filt_on)
		begin
			cnt_r <= `UVM_CNT_ZERO;
			dout  <= din; // R8
		end
		else if (din == dout)
			cnt_r <= `UVM_CNT_ZERO; // R7
		else if (tick)
		begin
			if (cnt_r + `UVM_CNT_ONE >= lim)
			begin
				dout  <= din; // R8
				cnt_r <= `UVM_CNT_ZERO;
			end
			else
				cnt_r <= cnt_r + `UVM_CNT_ONE;
		end
	end

endmodule // uvm_filter

// >>> uvm_undervoltage_monitor.v
// undervoltage monitor: source/threshold drive, filtering, triggers, actions
`timescale 1ns/1ps
`include "uvm_consts.vh"

module uvm_undervoltage_monitor
(
	input  wire       clk,
	input  wire       rst_b,
	input  wire       monitor_enable,
	input  wire [1:0] source_select,
	input  wire [3:0] threshold_code,
	input  wire       filter_enable_bit,
	input  wire       filter_clock_select,
	input  wire [2:0] filter_width_select,
	input  wire       level_trig_en,
	input  wire       fall_trig_en,
	input  wire       rise_trig_en,
	input  wire       action_reset,
	input  wire       irq_enable_bit,
	input  wire       irq_flag_clear_b,
	input  wire       reset_flag_clear_b,
	input  wire       comparator_out,
	input  wire       fast_internal_oscillator,
	input  wire       rc_osc_150k,
	output reg        analog_supply_sel,
	output reg  [2:0] pin_sel,
	output reg  [3:0] threshold_out,
	output reg        comparator_en,
	output reg        filtered_level,
	output reg        detector_output_pin,
	output reg        irq_flag,
	output reg        irq_out,
	output reg        reset_flag,
	output reg        reset_req
);

	reg  cmp_s1_r;
	reg  cmp_s2_r;
	reg  fck_s1_r;
	reg  fck_s2_r;
	reg  fck_d_r;
	reg  flt_d_r;
	reg  armed_r;
	wire fck_sel;
	wire flt;
	wire tick;
	wire fall_ev;
	wire rise_ev;
	wire trig;

	// pick filter clock source; the selected clock is sampled, not used as a clock
	assign fck_sel = filter_clock_select ? fast_internal_oscillator : rc_osc_150k; // R5

	// two-stage synchronisers for the comparator and filter clock
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
			fck_s1_r <= 1'b0;
			fck_s2_r <= 1'b0;
			fck_d_r  <= 1'b0;
		end
		else
		begin
			cmp_s1_r <= comparator_out;
			cmp_s2_r <= cmp_s1_r;
			fck_s1_r <= fck_sel;
			fck_s2_r <= fck_s1_r;
			fck_d_r  <= fck_s2_r;
		end
	end

	// a fast oscillator above clk/2 aliases; ticks are then only approximate
	assign tick = fck_s2_r & ~fck_d_r;

	uvm_filter u_filter
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.tick      (tick),
		.filt_on   (filter_enable_bit), // R4
		.width_sel (filter_width_select),
		.din       (cmp_s2_r),
		.dout      (flt)
	);

	// comparator high means below threshold: rising = voltage falling
	assign fall_ev = flt & ~flt_d_r; // R10 R13
	assign rise_ev = ~flt & flt_d_r; // R11 R14
	assign trig = monitor_enable & ((level_trig_en & flt) | (fall_trig_en & fall_ev)
		| (rise_trig_en & rise_ev)); // R12 R15

	// analog-side drive registers
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			analog_supply_sel <= 1'b1;
			pin_sel           <= 3'h0;
			threshold_out     <= `UVM_TH_RST;
			comparator_en     <= 1'b0;
		end
		else
		begin
			analog_supply_sel <= (source_select == `UVM_SRC_SUPPLY); // R1 R2
			pin_sel[0]        <= (source_select == `UVM_SRC_PIN_A); // R2
			pin_sel[1]        <= (source_select == `UVM_SRC_PIN_B); // R2
			pin_sel[2]        <= (source_select == `UVM_SRC_PIN_C); // R2
			threshold_out     <= threshold_code; // R3
			comparator_en     <= monitor_enable; // R21
		end
	end

	// level observation and edge history
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flt_d_r             <= 1'b0;
			filtered_level      <= 1'b0;
			detector_output_pin <= 1'b0;
		end
		else
		begin
			flt_d_r             <= flt;
			filtered_level      <= flt; // R9
			detector_output_pin <= flt; // R9
		end
	end

	// sticky flags; the set wins over a same-cycle clear so no event is lost
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_flag   <= 1'b0;
			reset_flag <= 1'b0;
			armed_r    <= 1'b1;
		end
		else
		begin
			// rearm only after software cleared the flag and trigger dropped
			if (!irq_flag && !reset_flag && !trig)
				armed_r <= 1'b1; // R20
			if (trig && armed_r)
			begin
				armed_r <= 1'b0;
				if (action_reset)
					reset_flag <= 1'b1; // R16 R17
				else
					irq_flag <= 1'b1; // R16 R17 R18
			end
			else
			begin
				if (!irq_flag_clear_b)
					irq_flag <= 1'b0; // R19 R20
				if (!reset_flag_clear_b)
					reset_flag <= 1'b0; // R20
			end
		end
	end

	// outputs toward the core; irq stays usable in low power for wake-up
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			irq_out   <= 1'b0;
			reset_req <= 1'b0;
		end
		else
		begin
			irq_out   <= irq_flag & irq_enable_bit; // R18 R21
			reset_req <= reset_flag; // R16
		end
	end

endmodule // uvm_undervoltage_monitor

// >>> uvm_chk_monitor.sv
// port assertions for the undervoltage monitor
`timescale 1ns/1ps
module uvm_chk_monitor
(
	input wire       clk,
	input wire       rst_b,
	input wire       monitor_enable,
	input wire [1:0] source_select,
	input wire [3:0] threshold_code,
	input wire       filter_enable_bit,
	input wire       action_reset,
	input wire       irq_enable_bit,
	input wire       irq_flag_clear_b,
	input wire       comparator_out,
	input wire       analog_supply_sel,
	input wire [2:0] pin_sel,
	input wire [3:0] threshold_out,
	input wire       filtered_level,
	input wire       detector_output_pin,
	input wire       irq_flag,
	input wire       reset_flag,
	input wire       irq_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// bypassed comparator held high for four samples
	sequence held_high_s;
		(monitor_enable && !filter_enable_bit && comparator_out) [*4];
	endsequence
	src_route_a: assert property (analog_supply_sel == ($past(source_select) == 2'h0))
		else $error("supply route");
	pin_route_a: assert property (pin_sel == {$past(source_select) == 2'h3,
		$past(source_select) == 2'h2, $past(source_select) == 2'h1}) else $error("pin route");
	thresh_drive_a: assert property (threshold_out == $past(threshold_code))
		else $error("threshold");
	pin_mirror_a: assert property (detector_output_pin == filtered_level)
		else $error("mirror");
	bypass_pass_a: assert property (held_high_s |-> ##[0:4] filtered_level)
		else $error("bypass");
	irq_path_a: assert property ($rose(irq_flag) |-> !$past(action_reset))
		else $error("irq path");
	irq_gate_a: assert property (irq_out == $past(irq_flag && irq_enable_bit))
		else $error("irq gate");
	irq_sticky_a: assert property (irq_flag && irq_flag_clear_b |=> irq_flag)
		else $error("sticky");
	reset_path_a: assert property ($rose(reset_flag) |-> $past(action_reset))
		else $error("reset path");
	bypass_path_a: assert property ($past(!filter_enable_bit, 2) |->
		filtered_level == $past(comparator_out, 4)) else $error("bypass path");
endmodule // uvm_chk_monitor
bind uvm_undervoltage_monitor uvm_chk_monitor uvm_chk_monitor_inst (.*);

// >>> uvm_cmp_model.sv
// comparator and filter clock model facing the monitor
`timescale 1ns/1ps
module uvm_cmp_model
(
	input  wire       comparator_en,
	input  wire [3:0] threshold_out,
	input  wire [7:0] level_dv,
	output wire       comparator_out,
	output reg        fast_internal_oscillator = 1'b0,
	output reg        rc_osc_150k = 1'b0
);
	// high while level (tenths of a volt) is under 1.8 V plus the code
	assign comparator_out = comparator_en && (level_dv < 8'h12 + {4'h0, threshold_out});
	// free-running 10 MHz and about 150 kHz filter clocks
	always #50 fast_internal_oscillator = ~fast_internal_oscillator;
	always #3333 rc_osc_150k = ~rc_osc_150k;
endmodule // uvm_cmp_model

// >>> uvm_tb.sv
// bench for the undervoltage monitor logic
`timescale 1ns/1ps
module tb;
	reg        clk = 1'b0, rst_b = 1'b0, monitor_enable = 1'b0, filter_enable_bit = 1'b0;
	reg  [1:0] source_select = 2'h0;
	reg  [3:0] threshold_code = 4'h0;
	reg  [2:0] filter_width_select = 3'h1;
	reg        filter_clock_select = 1'b1, level_trig_en = 1'b0, fall_trig_en = 1'b1;
	reg        rise_trig_en = 1'b1, action_reset = 1'b0, irq_enable_bit = 1'b1;
	reg        irq_flag_clear_b = 1'b1, reset_flag_clear_b = 1'b1;
	reg  [7:0] level_dv = 8'h22;
	wire       comparator_out, fast_internal_oscillator, rc_osc_150k, analog_supply_sel;
	wire       comparator_en, filtered_level, detector_output_pin, irq_flag, irq_out;
	wire       reset_flag, reset_req;
	wire [2:0] pin_sel;
	wire [3:0] threshold_out;
	integer    error_cnt = 0, tests_run = 0, cycles = 0, i, fw;
	uvm_undervoltage_monitor uvm_undervoltage_monitor_inst (.*);
	uvm_cmp_model uvm_cmp_model_inst (.*);
	// 40 MHz clock
	always #12.5 clk = ~clk;
	// hang guard, above the roughly 70000 cycles the whole bench needs
	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 80000)
		begin
			error_cnt = error_cnt + 1;
			wrap_up;
		end
	end
	// drive helpers, always just after the edge
	task cyc(input integer n); begin repeat (n) @(posedge clk); #2; end endtask
	task lv(input [7:0] v, input integer n); begin level_dv = v; cyc(n); end endtask
	task clr; begin irq_flag_clear_b = 1'b0; reset_flag_clear_b = 1'b0; cyc(1);
		irq_flag_clear_b = 1'b1; reset_flag_clear_b = 1'b1; cyc(2); end endtask
	task chk(input [3:0] e, input [3:0] a); begin tests_run = tests_run + 1;
		if (a !== e) begin error_cnt = error_cnt + 1;
		$display("ERROR %0t exp %h got %h", $time, e, a); end end endtask
	// filter clocks required per width code
	function integer fw_n(input [2:0] c);
	begin
		case (c)
			3'h0: fw_n = 1;
			3'h1: fw_n = 3;
			3'h2: fw_n = 7;
			3'h3: fw_n = 15;
			3'h4: fw_n = 63;
			3'h5: fw_n = 255;
			3'h6: fw_n = 1023;
			default: fw_n = 4095;
		endcase
	end
	endfunction
	task wrap_up;
	begin
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// routing, edge triggers, level with reset action, then filtering
	initial
	begin
		cyc(15);
		chk(4'h1, {irq_flag, reset_flag, irq_out, analog_supply_sel});
		cyc(1);
		rst_b = 1'b1;
		for (i = 0; i < 4; i = i + 1)
		begin
			source_select = i[1:0];
			threshold_code = {i[1:0], i[1:0]};
			cyc(2);
			chk(4'h1 << i, {pin_sel, analog_supply_sel});
			chk({i[1:0], i[1:0]}, threshold_out);
		end
		$display("test 1 done");
		clr;
		monitor_enable = 1'b1;
		lv(8'h20, 8);
		chk(4'hc, {irq_flag, irq_out, reset_flag, reset_req});
		chk(4'h1, {3'h0, comparator_en});
		clr;
		chk(4'h0, {irq_flag, irq_out, reset_flag, reset_req});
		lv(8'h22, 8);
		chk(4'hc, {irq_flag, irq_out, reset_flag, reset_req});
		clr;
		fall_trig_en = 1'b0;
		irq_enable_bit = 1'b0;
		lv(8'h20, 8);
		chk(4'h0, {irq_flag, irq_out, reset_flag, reset_req});
		lv(8'h22, 8);
		chk(4'h8, {irq_flag, irq_out, reset_flag, reset_req});
		clr;
		$display("test 2 done");
		rise_trig_en = 1'b0;
		level_trig_en = 1'b1;
		action_reset = 1'b1;
		lv(8'h20, 8);
		chk(4'h3, {irq_flag, irq_out, reset_flag, reset_req});
		clr;
		chk(4'h0, {irq_flag, irq_out, reset_flag, reset_req});
		lv(8'h22, 8);
		lv(8'h20, 8);
		chk(4'h3, {irq_flag, irq_out, reset_flag, reset_req});
		lv(8'h22, 4);
		clr;
		$display("test 3 done");
		level_trig_en = 1'b0;
		fall_trig_en = 1'b1;
		action_reset = 1'b0;
		irq_enable_bit = 1'b1;
		filter_enable_bit = 1'b1;
		for (i = 1; i >= 0; i = i - 1)
		begin
			filter_clock_select = i[0];
			lv(8'h20, i ? 6 : 400);
			lv(8'h22, i ? 40 : 1200);
			chk(4'h0, {2'h0, filtered_level, irq_flag});
			lv(8'h20, 40);
			chk({3'h0, i[0]}, {3'h0, filtered_level});
			cyc(i ? 0 : 1160);
			chk(4'hf, {filtered_level, detector_output_pin, irq_flag, irq_out});
			lv(8'h22, i ? 40 : 1200);
			clr;
		end
		$display("test 4 done");
		// every width code on the fast clock: one tick per four clk cycles
		filter_clock_select = 1'b1;
		for (i = 0; i < 8; i = i + 1)
		begin
			filter_width_select = i[2:0];
			fw = fw_n(i[2:0]);
			// a pulse two ticks short of the width must vanish
			if (fw > 1)
				lv(8'h20, 4 * fw - 8);
			lv(8'h22, 8);
			chk(4'h0, {3'h0, filtered_level});
			lv(8'h20, 4 * fw + 8);
			chk(4'h1, {3'h0, filtered_level});
			lv(8'h22, 4 * fw + 8);
			chk(4'h0, {3'h0, filtered_level});
		end
		clr;
		$display("test 5 done");
		wrap_up;
	end
endmodule // tb
